// [shared/mode_pins_pkg.sv]
// Package for the multiplexed control pin decoder of a dual converter.
// Assumes one core clock domain; all pins arrive asynchronous.
package mode_pins_pkg;
  localparam int  DATA_W       = 14;
  localparam int  SYNC_STAGES  = 2;
  localparam logic RESET_LVL   = 1'b0;
  localparam logic FMT_BINARY  = 1'b0;
  localparam logic FMT_TWOS    = 1'b1;
  localparam logic PHASE_SAME  = 1'b0;

  typedef enum logic [1:0] {
    PHASE_DIRECT,
    PHASE_WAIT,
    PHASE_ARMED
  } retimeState_t;

  // Serial-port facing signals
  typedef struct packed {
    logic serClk;
    logic serDataIn;
    logic serSelN;
  } serialPins_t;

  // Pin-mode configuration
  typedef struct packed {
    logic twosComp;
    logic powerDown;
    logic retimeArmed;
  } pinConfig_t;
endpackage : mode_pins_pkg

// [src/pin_sync.sv]
// Two-flop level synchroniser, width parameterised.
// Assumes inputs are asynchronous to core_clk.
`timescale 1ns/100ps
module pin_sync
  import mode_pins_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_q;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stage1_q <= '0;
      syncOut  <= '0;
    end else begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end
  end
endmodule : pin_sync

// [src/mode_pin_decoder.sv]
// Decoder for the mode strap and the three shared control pins.
// Assumes core_clk samples all pins, including the qualify clock.
`timescale 1ns/100ps
// Operation
// [RULE1] Strap low selects serial-port mode; shared pins carry serial functions.
// [RULE2] Strap high pulse in serial mode restores serial registers to defaults.
// [RULE3] Strap high selects pin mode; shared pins become configuration inputs.
// [RULE4] Serial mode: clock/phase pin is the serial clock from host.
// [RULE5] Serial mode: data pin is bidirectional, each side drives its phase.
// [RULE6] Serial mode: select pin is active-low; traffic honoured only while low.
// [RULE7] Pin mode: phase pin sets the retiming clock phase.
// [RULE8] Host holds phase pin at zero when both clocks are the same.
// [RULE9] Pin mode: phase pin rising edge triggers the internal retime.
// [RULE10] Pin mode: format pin low means straight binary samples.
// [RULE11] Pin mode: format pin high means twos complement samples.
// [RULE12] Pin mode: power-down pin high powers down all but serial port.
// [RULE13] Sample data is qualified by the data-qualifying clock.
// [RULE14] Format and power-down are synchronised before use.
module mode_pin_decoder
  import mode_pins_pkg::*;
#(
  parameter int DW = DATA_W
) (
  input  wire logic          core_clk,
  input  wire logic          reset,
  input  wire logic          pin_control_mode,
  input  wire logic          clkPhasePin,
  input  wire logic          dataFmtPinIn,
  output logic               dataFmtPinOut,
  output logic               dataFmtPinOe,
  input  wire logic          selPwrPin,
  input  wire logic          data_qualify_clock,
  input  wire logic [DW-1:0] sampleIn,
  input  wire logic          serDataOut,
  input  wire logic          serDataDrive,
  output serialPins_t        serialPins,
  output logic               serialActive,
  output logic               serialRegReset,
  output pinConfig_t         pinConfig,
  output logic               retimeTrigger,
  output logic [DW-1:0]      sampleOut,
  output logic               sampleValid
);
  // Strap, phase, format, select and qualify clock
  localparam int PIN_COUNT = 5;

  logic [PIN_COUNT-1:0] syncRaw;
  logic [PIN_COUNT-1:0] syncd;
  logic       strapS;
  logic       phaseS;
  logic       fmtS;
  logic       selS;
  logic       dclkS;
  logic       strapPrev_q;
  logic       phasePrev_q;
  logic       dclkPrev_q;
  logic [DW-1:0] dataS1_q;
  logic [DW-1:0] dataS2_q;
  retimeState_t state_q;
  retimeState_t state_d;
  logic       pinMode;
  logic       phaseRise;
  logic       dclkRise;
  logic       strapFall;
  pinConfig_t cfg_d;
  pinConfig_t cfg_q;

  localparam serialPins_t SER_IDLE = '{serClk: 1'b0, serDataIn: 1'b0, serSelN: 1'b1};

  // Rising edge of a synced level against its last value
  function automatic logic risingEdge(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction : risingEdge

  assign syncRaw = {pin_control_mode, clkPhasePin, dataFmtPinIn, selPwrPin,
                    data_qualify_clock};

  // [RULE14] Two flops on every pin
  pin_sync #(.WIDTH(PIN_COUNT)) uSync (
    .core_clk (core_clk),
    .reset    (reset),
    .asyncIn  (syncRaw),
    .syncOut  (syncd)
  );

  assign {strapS, phaseS, fmtS, selS, dclkS} = syncd;

  // [RULE1] Strap low means serial mode
  // [RULE3] Strap high means pin mode
  assign pinMode   = strapS;
  assign phaseRise = risingEdge(phaseS, phasePrev_q);
  assign dclkRise  = risingEdge(dclkS, dclkPrev_q);
  assign strapFall = ~strapS & strapPrev_q;

  // [RULE4] Phase pin routed as serial clock
  // Pin mode parks the serial lines deselected
  assign serialPins = pinMode ? SER_IDLE : serialPins_t'({phaseS, fmtS, selS});

  // [RULE6] Active only while select low
  assign serialActive = ~pinMode & ~selS;

  // [RULE5] Drive data pin only in device phase
  assign dataFmtPinOe  = ~pinMode & ~selS & serDataDrive;
  assign dataFmtPinOut = serDataOut;

  // Phase already high on entry waits for a fresh rise
  // [RULE7] Phase pin low runs retime direct until a rise arms it
  always_comb begin
    state_d = state_q;
    case (state_q)
      PHASE_DIRECT: if (pinMode && phaseS != PHASE_SAME) state_d = PHASE_WAIT;
      PHASE_WAIT:   if (!pinMode || phaseS == PHASE_SAME) state_d = PHASE_DIRECT;
      PHASE_ARMED:  if (!pinMode) state_d = PHASE_DIRECT;
      default:      state_d = PHASE_DIRECT;
    endcase
    // [RULE9] Rising edge arms retime
    if (pinMode && phaseRise) state_d = PHASE_ARMED;
  end

  // [RULE10] Low format is binary
  // [RULE11] High format is twos complement
  // [RULE12] Power-down only in pin mode
  always_comb begin
    cfg_d             = cfg_q;
    cfg_d.retimeArmed = (state_d == PHASE_ARMED);
    if (pinMode) begin
      cfg_d.twosComp  = (fmtS == FMT_TWOS);
      cfg_d.powerDown = selS;
    end else begin
      cfg_d.twosComp  = FMT_BINARY;
      cfg_d.powerDown = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      strapPrev_q <= RESET_LVL;
      phasePrev_q <= 1'b0;
      dclkPrev_q  <= 1'b0;
      state_q     <= PHASE_DIRECT;
      cfg_q       <= '0;
    end else begin
      strapPrev_q <= strapS;
      phasePrev_q <= phaseS;
      dclkPrev_q  <= dclkS;
      state_q     <= state_d;
      cfg_q       <= cfg_d;
    end
  end

  assign pinConfig = cfg_q;

  // Held high in reset so serial registers start at defaults
  // [RULE2] Strap pulse resets serial registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      serialRegReset <= 1'b1;
      retimeTrigger  <= 1'b0;
    end else begin
      serialRegReset <= strapFall;
      retimeTrigger  <= pinMode & phaseRise;
    end
  end

  // Data sampled twice; host holds it steady around the qualify edge
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dataS1_q    <= '0;
      dataS2_q    <= '0;
      sampleOut   <= '0;
      sampleValid <= 1'b0;
    end else begin
      dataS1_q    <= sampleIn;
      dataS2_q    <= dataS1_q;
      // [RULE13] Capture on qualify clock edge
      sampleValid <= dclkRise & ~cfg_q.powerDown;
      if (dclkRise && !cfg_q.powerDown) begin
        sampleOut <= dataS2_q;
      end
    end
  end

  // [RULE2] Pulse after strap fall
  chk_strap_reset: assert property (@(posedge core_clk) disable iff (reset) // [RULE2]
    strapFall |=> serialRegReset) else $error("serial reset missed");
  // [RULE5] No drive in pin mode
  chk_data_drive: assert property (@(posedge core_clk) disable iff (reset) // [RULE5]
    pinMode |-> !dataFmtPinOe) else $error("data pin driven in pin mode");
  // [RULE6] Select high blocks traffic
  chk_select_gate: assert property (@(posedge core_clk) disable iff (reset) // [RULE6]
    selS |-> !serialActive && !dataFmtPinOe) else $error("active while deselected");
  // [RULE9] Edge gives trigger
  chk_retime_edge: assert property (@(posedge core_clk) disable iff (reset) // [RULE9]
    (pinMode && phaseRise) |=> retimeTrigger ##0 pinConfig.retimeArmed)
    else $error("retime edge lost");
  // [RULE11] Format high gives twos
  chk_fmt_twos: assert property (@(posedge core_clk) disable iff (reset) // [RULE11]
    (pinMode && fmtS) |=> pinConfig.twosComp) else $error("format not twos");
  // [RULE10] Format low gives binary
  chk_fmt_bin: assert property (@(posedge core_clk) disable iff (reset) // [RULE10]
    !fmtS |=> !pinConfig.twosComp) else $error("format not binary");
  // [RULE12] Power-down follows pin
  chk_power_down: assert property (@(posedge core_clk) disable iff (reset) // [RULE12]
    (pinMode && selS) |=> pinConfig.powerDown ##1 !sampleValid)
    else $error("power down ignored");
  // [RULE1] Serial mode keeps power on
  chk_serial_mode: assert property (@(posedge core_clk) disable iff (reset) // [RULE1]
    !pinMode |=> !pinConfig.powerDown) else $error("power down in serial mode");
  // [RULE13] Valid only after qualify edge
  chk_qualify_edge: assert property (@(posedge core_clk) disable iff (reset) // [RULE13]
    sampleValid |-> $past(dclkRise)) else $error("sample without qualify edge");

  // [RULE2] Reset pulse lasts one cycle
  chk_strap_once: assert property (@(posedge core_clk) disable iff (reset) // [RULE2]
    serialRegReset |=> !serialRegReset) else $error("serial reset too long");
  // [RULE3] No retime outside pin mode
  chk_retime_refuse: assert property (@(posedge core_clk) disable iff (reset) // [RULE3]
    !pinMode |=> !retimeTrigger) else $error("retime in serial mode");
  // [RULE7] Armed phase holds in pin mode
  chk_armed_hold: assert property (@(posedge core_clk) disable iff (reset) // [RULE7]
    (pinMode && pinConfig.retimeArmed) |=> pinConfig.retimeArmed)
    else $error("retime phase dropped");
  // [RULE14] Config lags the synced pin
  chk_sync_lag: assert property (@(posedge core_clk) disable iff (reset) // [RULE14]
    ($rose(fmtS) && $past(pinMode)) |-> !pinConfig.twosComp)
    else $error("format used before sync");

  cov_serial_xfer: cover property (@(posedge core_clk) serialActive [*4]);
  cov_strap_pulse: cover property (@(posedge core_clk) disable iff (reset)
    strapFall ##1 serialRegReset);
  cov_retime: cover property (@(posedge core_clk) retimeTrigger);
  cov_sample: cover property (@(posedge core_clk) sampleValid ##[1:40] sampleValid);
  cov_power_down: cover property (@(posedge core_clk) pinConfig.powerDown && dclkRise);
endmodule : mode_pin_decoder

// [tb/host_model.sv]
// Host model: data-qualify clock and sample words.
// Assumes the bench raises run only for sample frames.
`timescale 1ns/100ps
module host_model
  import mode_pins_pkg::*;
(
  input  wire logic        run,
  output logic             qualClk,
  output logic [DATA_W-1:0] word
);
  initial begin
    qualClk = 1'b0;
    word    = 14'h0000;
  end
  always begin
    #80;
    if (run && !qualClk) begin
      qualClk = 1'b1;
    end else begin
      qualClk = 1'b0;
      // Idle: clock stands still, data keeps moving
      word    = run ? word + 14'h0001 : ~word;
    end
  end
endmodule : host_model

// [tb/dual_dac_mode_control_pins_tb.sv]
// Bench for the mode pin decoder with a host model.
// Assumes 125 MHz core_clk; bench pins driven at rising edges, host pins at falling edges.
`timescale 1ns/100ps
module dual_dac_mode_control_pins_tb;
  import mode_pins_pkg::*;
  logic core_clk = 1'b0, reset = 1'b1, strap = 1'b0, phase = 1'b0;
  logic fmt = 1'b0, sel = 1'b1, sdo = 1'b0, sdrv = 1'b0, run = 1'b0;
  logic fOut, fOe, act, regRst, trig, sVal, qClk, hit;
  logic [DATA_W-1:0] sOut, word;
  serialPins_t ser;
  pinConfig_t cfg;
  int fail_count = 0, checked = 0, cycles = 0;
  wire pinLvl = fOe ? fOut : fmt;
  always #4 core_clk = ~core_clk;
  host_model host (.run(run), .qualClk(qClk), .word(word));
  mode_pin_decoder dut (.core_clk(core_clk), .reset(reset), .pin_control_mode(strap),
    .clkPhasePin(phase), .dataFmtPinIn(pinLvl), .dataFmtPinOut(fOut),
    .dataFmtPinOe(fOe), .selPwrPin(sel), .data_qualify_clock(qClk), .sampleIn(word),
    .serDataOut(sdo), .serDataDrive(sdrv), .serialPins(ser), .serialActive(act),
    .serialRegReset(regRst), .pinConfig(cfg), .retimeTrigger(trig),
    .sampleOut(sOut), .sampleValid(sVal));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (e !== g) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic t_serial;
    @(posedge core_clk) begin strap <= 1'b0; sel <= 1'b0; phase <= 1'b1; end
    @(posedge core_clk) begin sdrv <= 1'b1; sdo <= 1'b1; end
    cyc(5);
    chk("active", 1, act);
    chk("serSelN", 0, ser.serSelN);
    chk("serClk", 1, ser.serClk);
    chk("dataOe", 1, fOe);
    chk("dataPin", 1, pinLvl);
    @(posedge core_clk) sel <= 1'b1;
    cyc(5);
    chk("idle", 3'b001, {act, fOe, ser.serSelN});
    @(posedge core_clk) begin sdrv <= 1'b0; phase <= 1'b0; fmt <= 1'b1; end
    cyc(5);
    chk("serIn", 1, ser.serDataIn);
    chk("serClkLow", 0, ser.serClk);
  endtask : t_serial
  task automatic t_strap;
    @(posedge core_clk) strap <= 1'b1;
    @(posedge core_clk) sel <= 1'b0;
    cyc(5);
    chk("pinMode", 4'h1, {act, ser});
    @(posedge core_clk) strap <= 1'b0;
    hit = 1'b0;
    repeat (8) begin
      cyc(1);
      if (regRst === 1'b1) hit = 1'b1;
    end
    chk("regReset", 1, hit);
  endtask : t_strap
  task automatic t_cfg;
    // Phase pin left low, no retime wanted
    @(posedge core_clk) begin strap <= 1'b1; fmt <= 1'b1; sel <= 1'b1; end
    cyc(1);
    chk("syncLag", 0, cfg);
    cyc(5);
    chk("twosPwr", 3'b110, cfg);
    @(posedge core_clk) begin fmt <= 1'b0; sel <= 1'b0; end
    cyc(5);
    chk("binary", 0, cfg);
  endtask : t_cfg
  task automatic t_retime;
    @(posedge core_clk) phase <= 1'b1;
    hit = 1'b0;
    repeat (6) begin
      cyc(1);
      if (trig === 1'b1) hit = 1'b1;
    end
    chk("trigger", 1, hit);
    chk("armed", 1, cfg.retimeArmed);
  endtask : t_retime
  task automatic t_sample;
    @(posedge core_clk) run <= 1'b1;
    repeat (3) begin
      hit = 1'b0;
      repeat (60) if (!hit) begin
        cyc(1);
        hit = (sVal === 1'b1);
      end
      chk("valid", 1, hit);
      chk("sample", {2'b00, word}, {2'b00, sOut});
    end
    // Power-down must swallow qualify edges
    @(posedge core_clk) sel <= 1'b1;
    cyc(4);
    hit = 1'b0;
    repeat (45) begin
      cyc(1);
      if (sVal !== 1'b0) hit = 1'b1;
    end
    chk("pdBlock", 0, hit);
    @(posedge core_clk) begin sel <= 1'b0; run <= 1'b0; end
  endtask : t_sample
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // Ceiling well above the few hundred cycles needed
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    cyc(3);
    t_serial();
    t_strap();
    t_cfg();
    t_retime();
    t_sample();
    finish_test();
  end
endmodule : dual_dac_mode_control_pins_tb
